// file: hw/occ_ctrl.sv
// Oscillator control and status register with APB slave and switch sequencer
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/10ps

// Operation
// - PLL output divider code 000..110 divides by 1..64, 111 by 256
// - Fast RC divider uses same encoding, resets to divide by two
// - Secondary oscillator ready reads one only when running and stable
// - Peripheral divisor ready shows whether divisor writes are accepted
// - Peripheral divisor code divides system clock by 1, 2, 4 or 8
// - PLL multiplier codes give 15 through 21, and 24
// - Current source field reports oscillator now driving system clock
// - Eight-code clock source encoding shared by current and new fields
// - New source field writable, loaded from initial source config on reset
// - Lock bit freezes clock and PLL selections when monitor config is 1x
// - With monitor config 0x selections are never locked
// - USB PLL locked bit reflects USB PLL lock or expired timer
// - System PLL locked bit reflects PLL lock or expired timer
// - Sleep on wait bit: one Sleep, zero Idle
// - Control writes accepted only after a two-key unlock sequence
// - Unimplemented bits read zero and ignore writes
// - Config fields load on reset; divisor ready one; fail flag, lock and current source zero
// - Setting switch request starts switch; hardware clears it when done
// - Clock fail flag set when monitor detects failure
// - USB fast RC select chooses USB clock source
// - Secondary oscillator enable bit turns that oscillator on or off
module occ_ctrl
	import occ_pkg::*;
(
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic NRST,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Configuration words
	input wire logic [2:0] CFG_INITIAL_SOURCE,
	input wire logic [1:0] CFG_SWITCH_MONITOR,
	input wire logic [2:0] CFG_PLL_OUTPUT_DIVIDER,
	input wire logic [2:0] CFG_PLL_MULTIPLIER,
	input wire logic [1:0] CFG_PERIPH_BUS_DIVISOR,
	input wire logic CFG_SECONDARY_OSC_ENABLE,
	// Oscillator status
	input wire logic SECONDARY_OSC_STABLE,
	input wire logic USB_PLL_LOCKED,
	input wire logic SYSTEM_PLL_LOCKED,
	input wire logic FAIL_SAFE_MONITOR_FAIL,
	input wire logic NEW_SOURCE_READY,
	// Clock controls
	output logic [2:0] CURRENT_SOURCE,
	output logic [8:0] PLL_OUTPUT_RATIO,
	output logic [8:0] FAST_RC_RATIO,
	output logic [4:0] PLL_MULT_RATIO,
	output logic PERIPHERAL_BUS_CLOCK_EN,
	output logic SLEEP_ON_WAIT,
	output logic USB_FAST_RC_SELECT,
	output logic SECONDARY_OSC_ENABLE
);
	// ************************************************************
	// State
	// ************************************************************
	logic [2:0] odiv_reg, odiv_next;
	logic [2:0] fast_rc_divider_reg, fast_rc_divider_next;
	logic [1:0] periph_bus_divisor_reg, periph_bus_divisor_next;
	logic [2:0] mult_reg, mult_next;
	logic [2:0] current_source_reg, current_source_next;
	logic [2:0] new_source_reg, new_source_next;
	logic lock_reg, lock_next;
	logic sleep_on_wait_reg, sleep_on_wait_next;
	logic cf_reg, cf_next;
	logic ufrc_reg, ufrc_next;
	logic secondary_osc_enable_reg, secondary_osc_enable_next;
	logic switch_request_reg, switch_request_next;
	occ_sw_t sw_reg, sw_next;
	occ_unl_t unl_reg, unl_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	logic [8:0] odiv_ratio_reg, frc_ratio_reg;
	logic [4:0] mult_ratio_reg;
	logic setup, access_wr, ctrl_wr, key_wr, mapped;
	logic sel_locked, pb_load, pb_tick, pb_ready;
	logic [31:0] ctrl_word;

	// ************************************************************
	// APB decode
	// ************************************************************
	always_comb begin
		setup = PSEL && !PENABLE;
		access_wr = PSEL && PENABLE && PWRITE && pready_reg;
		if (PADDR == OCC_CTRL_ADDR) begin
			mapped = 1'b1;
		end else if (PADDR == OCC_KEY_ADDR) begin
			mapped = 1'b1;
		end else begin
			mapped = 1'b0;
		end
		ctrl_wr = access_wr && (PADDR == OCC_CTRL_ADDR) && (unl_reg == OCC_UNL_OPEN);
		key_wr = access_wr && (PADDR == OCC_KEY_ADDR);
		sel_locked = lock_reg && CFG_SWITCH_MONITOR[OCC_SWMON_LOCK_BIT];
		pb_load = ctrl_wr && pb_ready && (PWDATA[OCC_PERIPH_BUS_DIVISOR_LSB +: 2] != periph_bus_divisor_reg);
	end

	// Read image; unimplemented bits stay zero
	always_comb begin
		ctrl_word = '0;
		ctrl_word[OCC_ODIV_LSB +: 3] = odiv_reg;
		ctrl_word[OCC_FAST_RC_DIVIDER_LSB +: 3] = fast_rc_divider_reg;
		ctrl_word[OCC_SECONDARY_OSC_READY_BIT] = SECONDARY_OSC_STABLE && secondary_osc_enable_reg;
		ctrl_word[OCC_PBRDY_BIT] = pb_ready;
		ctrl_word[OCC_PERIPH_BUS_DIVISOR_LSB +: 2] = periph_bus_divisor_reg;
		ctrl_word[OCC_MULT_LSB +: 3] = mult_reg;
		ctrl_word[OCC_CURRENT_SOURCE_LSB +: 3] = current_source_reg;
		ctrl_word[OCC_NEW_SOURCE_LSB +: 3] = new_source_reg;
		ctrl_word[OCC_LOCK_BIT] = lock_reg;
		ctrl_word[OCC_USB_PLL_LOCKED_BIT] = USB_PLL_LOCKED;
		ctrl_word[OCC_SYSTEM_PLL_LOCKED_BIT] = SYSTEM_PLL_LOCKED;
		ctrl_word[OCC_SLEEP_ON_WAIT_BIT] = sleep_on_wait_reg;
		ctrl_word[OCC_CF_BIT] = cf_reg;
		ctrl_word[OCC_UFRC_BIT] = ufrc_reg;
		ctrl_word[OCC_SECONDARY_OSC_ENABLE_BIT] = secondary_osc_enable_reg;
		ctrl_word[OCC_SWITCH_REQUEST_BIT] = switch_request_reg;
	end

	// ************************************************************
	// Bus answer: no wait state, read data captured at setup
	// ************************************************************
	always_comb begin
		pready_next = setup;
		pslverr_next = setup && !mapped;
		prdata_next = prdata_reg;
		if (setup && !PWRITE) begin
			prdata_next = (PADDR == OCC_CTRL_ADDR) ? ctrl_word : '0;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			prdata_reg <= '0;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	// ************************************************************
	// Unlock sequence: two keys, opens one control write
	// ************************************************************
	always_comb begin
		unl_next = unl_reg;
		if (key_wr) begin
			if (PWDATA == OCC_KEY_FIRST) begin
				unl_next = OCC_UNL_HALF;
			end else if (PWDATA == OCC_KEY_SECOND && unl_reg == OCC_UNL_HALF) begin
				unl_next = OCC_UNL_OPEN;
			end else begin
				unl_next = OCC_UNL_NONE;
			end
		end else if (ctrl_wr) begin
			unl_next = OCC_UNL_NONE;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			unl_reg <= OCC_UNL_NONE;
		end else begin
			unl_reg <= unl_next;
		end
	end

	// ************************************************************
	// Control fields and switch sequencer
	// ************************************************************
	always_comb begin
		odiv_next = odiv_reg;
		fast_rc_divider_next = fast_rc_divider_reg;
		periph_bus_divisor_next = periph_bus_divisor_reg;
		mult_next = mult_reg;
		new_source_next = new_source_reg;
		lock_next = lock_reg;
		sleep_on_wait_next = sleep_on_wait_reg;
		ufrc_next = ufrc_reg;
		secondary_osc_enable_next = secondary_osc_enable_reg;
		switch_request_next = switch_request_reg;
		current_source_next = current_source_reg;
		cf_next = cf_reg;
		sw_next = sw_reg;
		if (ctrl_wr) begin
			fast_rc_divider_next = PWDATA[OCC_FAST_RC_DIVIDER_LSB +: 3];
			lock_next = PWDATA[OCC_LOCK_BIT];
			sleep_on_wait_next = PWDATA[OCC_SLEEP_ON_WAIT_BIT];
			ufrc_next = PWDATA[OCC_UFRC_BIT];
			secondary_osc_enable_next = PWDATA[OCC_SECONDARY_OSC_ENABLE_BIT];
			// Only a write of zero clears the fail flag
			if (!PWDATA[OCC_CF_BIT]) begin
				cf_next = 1'b0;
			end
			if (pb_ready) begin
				periph_bus_divisor_next = PWDATA[OCC_PERIPH_BUS_DIVISOR_LSB +: 2];
			end
			if (!sel_locked && !switch_request_reg) begin
				odiv_next = PWDATA[OCC_ODIV_LSB +: 3];
				mult_next = PWDATA[OCC_MULT_LSB +: 3];
				new_source_next = PWDATA[OCC_NEW_SOURCE_LSB +: 3];
				switch_request_next = PWDATA[OCC_SWITCH_REQUEST_BIT];
			end
		end
		// Set wins over a simultaneous software clear
		if (FAIL_SAFE_MONITOR_FAIL) begin
			cf_next = 1'b1;
		end
		case (sw_reg)
			OCC_SW_IDLE: begin
				if (switch_request_reg) begin
					sw_next = OCC_SW_WAIT;
				end
			end
			OCC_SW_WAIT: begin
				if (NEW_SOURCE_READY) begin
					sw_next = OCC_SW_DONE;
				end
			end
			OCC_SW_DONE: begin
				current_source_next = new_source_reg;
				switch_request_next = 1'b0;
				sw_next = OCC_SW_IDLE;
			end
			default: begin
				sw_next = OCC_SW_IDLE;
			end
		endcase
	end

	// Reset is synchronous, so sampling the config words here is safe
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			odiv_reg <= CFG_PLL_OUTPUT_DIVIDER;
			fast_rc_divider_reg <= OCC_FAST_RC_DIVIDER_RST;
			periph_bus_divisor_reg <= CFG_PERIPH_BUS_DIVISOR;
			mult_reg <= CFG_PLL_MULTIPLIER;
			new_source_reg <= CFG_INITIAL_SOURCE;
			current_source_reg <= OCC_CURRENT_SOURCE_RST;
			secondary_osc_enable_reg <= CFG_SECONDARY_OSC_ENABLE;
			lock_reg <= 1'b0;
			sleep_on_wait_reg <= 1'b0;
			cf_reg <= 1'b0;
			ufrc_reg <= 1'b0;
			switch_request_reg <= 1'b0;
			sw_reg <= OCC_SW_IDLE;
			odiv_ratio_reg <= occ_div_ratio(CFG_PLL_OUTPUT_DIVIDER);
			frc_ratio_reg <= occ_div_ratio(OCC_FAST_RC_DIVIDER_RST);
			mult_ratio_reg <= occ_mult_ratio(CFG_PLL_MULTIPLIER);
		end else begin
			odiv_reg <= odiv_next;
			fast_rc_divider_reg <= fast_rc_divider_next;
			periph_bus_divisor_reg <= periph_bus_divisor_next;
			mult_reg <= mult_next;
			new_source_reg <= new_source_next;
			current_source_reg <= current_source_next;
			secondary_osc_enable_reg <= secondary_osc_enable_next;
			lock_reg <= lock_next;
			sleep_on_wait_reg <= sleep_on_wait_next;
			cf_reg <= cf_next;
			ufrc_reg <= ufrc_next;
			switch_request_reg <= switch_request_next;
			sw_reg <= sw_next;
			odiv_ratio_reg <= occ_div_ratio(odiv_next);
			frc_ratio_reg <= occ_div_ratio(fast_rc_divider_next);
			mult_ratio_reg <= occ_mult_ratio(mult_next);
		end
	end

	// ************************************************************
	// Peripheral bus clock enable
	// ************************************************************
	occ_periph_bus_divisor #(.CNT_W(3)) u_periph_bus_divisor (
		.clk(SYS_CLK),
		.nrst(NRST),
		.div_code(periph_bus_divisor_next),
		.load(pb_load),
		.tick(pb_tick),
		.ready(pb_ready)
	);

	assign PRDATA = prdata_reg;
	assign PREADY = pready_reg;
	assign PSLVERR = pslverr_reg;
	assign CURRENT_SOURCE = current_source_reg;
	assign PLL_OUTPUT_RATIO = odiv_ratio_reg;
	assign FAST_RC_RATIO = frc_ratio_reg;
	assign PLL_MULT_RATIO = mult_ratio_reg;
	assign PERIPHERAL_BUS_CLOCK_EN = pb_tick;
	assign SLEEP_ON_WAIT = sleep_on_wait_reg;
	assign USB_FAST_RC_SELECT = ufrc_reg;
	assign SECONDARY_OSC_ENABLE = secondary_osc_enable_reg;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!NRST);

	sequence s_sw_arm;
		switch_request_reg && sw_reg == OCC_SW_IDLE;
	endsequence

	sequence s_sw_enter_wait;
		##1 sw_reg == OCC_SW_WAIT;
	endsequence

	a_lock_freezes_sel: assert property (ctrl_wr && sel_locked |=>
		$stable(new_source_reg) && $stable(mult_reg) && $stable(odiv_reg))
		else $error("Locked selection changed");
	a_lock_never_cfg0: assert property (ctrl_wr && !CFG_SWITCH_MONITOR[OCC_SWMON_LOCK_BIT] &&
		!switch_request_reg |=> new_source_reg == $past(PWDATA[OCC_NEW_SOURCE_LSB +: 3]))
		else $error("Selection locked while monitor enabled");
	a_unlock_gates_wr: assert property (access_wr && PADDR == OCC_CTRL_ADDR &&
		unl_reg != OCC_UNL_OPEN |=> $stable(sleep_on_wait_reg) && $stable(secondary_osc_enable_reg))
		else $error("Control write accepted without unlock");
	a_periph_bus_divisor_blocked: assert property (ctrl_wr && !pb_ready |=> $stable(periph_bus_divisor_reg))
		else $error("Divisor written while not ready");
	a_switch_starts: assert property (s_sw_arm |-> s_sw_enter_wait)
		else $error("Switch request did not start sequencer");
	a_switch_done: assert property (sw_reg == OCC_SW_DONE |=>
		current_source_reg == $past(new_source_reg) && !switch_request_reg) else $error("Switch completion wrong");
	a_fail_sticky: assert property (FAIL_SAFE_MONITOR_FAIL |=> cf_reg ##1
		(cf_reg || $past(ctrl_wr && !PWDATA[OCC_CF_BIT])))
		else $error("Fail flag not held");
	a_rsvd_zero: assert property ((PRDATA & OCC_RSVD_MASK) == '0)
		else $error("Unimplemented bit read nonzero");
	a_sosc_ready_rd: assert property (setup && !PWRITE && PADDR == OCC_CTRL_ADDR |=>
		PRDATA[OCC_SECONDARY_OSC_READY_BIT] == $past(SECONDARY_OSC_STABLE && secondary_osc_enable_reg))
		else $error("Secondary ready read wrong");
	a_reset_values: assert property ($past(!NRST) |-> fast_rc_divider_reg == OCC_FAST_RC_DIVIDER_RST &&
		pb_ready && !cf_reg && !lock_reg && current_source_reg == OCC_CURRENT_SOURCE_RST)
		else $error("Reset value wrong");

endmodule // occ_ctrl

// file: hw/occ_periph_bus_divisor.sv
// Peripheral bus clock enable divider with divisor-ready status
`timescale 1ns/10ps

module occ_periph_bus_divisor
	import occ_pkg::*;
#(
	parameter int CNT_W = 3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Control
	input wire logic [1:0] div_code,
	input wire logic load,
	// Status
	output logic tick,
	output logic ready
);
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic [CNT_W-1:0] limit;
	logic tick_reg;
	logic tick_next;
	logic ready_reg;
	logic ready_next;

	// ************************************************************
	// Divide by 1, 2, 4 or 8
	// ************************************************************
	always_comb begin
		limit = CNT_W'((4'h1 << div_code) - 4'h1);
		tick_next = 1'b0;
		cnt_next = cnt_reg;
		ready_next = ready_reg;
		if (load) begin
			// Restart so the new divisor never produces a runt period
			cnt_next = '0;
			ready_next = 1'b0;
		end else if (cnt_reg >= limit) begin
			cnt_next = '0;
			tick_next = 1'b1;
			ready_next = 1'b1;
		end else begin
			cnt_next = cnt_reg + CNT_W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			cnt_reg <= '0;
			tick_reg <= 1'b0;
			ready_reg <= 1'b1;
		end else begin
			cnt_reg <= cnt_next;
			tick_reg <= tick_next;
			ready_reg <= ready_next;
		end
	end

	assign tick = tick_reg;
	assign ready = ready_reg;

endmodule // occ_periph_bus_divisor

// file: hw/occ_pkg.sv
// Package: oscillator control register map, field layout, encodings and constants
package occ_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [11:0] OCC_CTRL_ADDR = 12'h000;
	localparam logic [11:0] OCC_KEY_ADDR = 12'h010;
	localparam logic [31:0] OCC_KEY_FIRST = 32'h5a5a_0f0f;
	localparam logic [31:0] OCC_KEY_SECOND = 32'ha5a5_f0f0;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int OCC_ODIV_LSB = 27;
	localparam int OCC_FAST_RC_DIVIDER_LSB = 24;
	localparam int OCC_SECONDARY_OSC_READY_BIT = 22;
	localparam int OCC_PBRDY_BIT = 21;
	localparam int OCC_PERIPH_BUS_DIVISOR_LSB = 19;
	localparam int OCC_MULT_LSB = 16;
	localparam int OCC_CURRENT_SOURCE_LSB = 12;
	localparam int OCC_NEW_SOURCE_LSB = 8;
	localparam int OCC_LOCK_BIT = 7;
	localparam int OCC_USB_PLL_LOCKED_BIT = 6;
	localparam int OCC_SYSTEM_PLL_LOCKED_BIT = 5;
	localparam int OCC_SLEEP_ON_WAIT_BIT = 4;
	localparam int OCC_CF_BIT = 3;
	localparam int OCC_UFRC_BIT = 2;
	localparam int OCC_SECONDARY_OSC_ENABLE_BIT = 1;
	localparam int OCC_SWITCH_REQUEST_BIT = 0;
	localparam int OCC_SWMON_LOCK_BIT = 1;
	localparam logic [31:0] OCC_RSVD_MASK = 32'hc080_8800;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [2:0] OCC_FAST_RC_DIVIDER_RST = 3'h1;
	localparam logic [2:0] OCC_CURRENT_SOURCE_RST = 3'h0;

	// ************************************************************
	// Encodings and states
	// ************************************************************
	typedef enum logic [2:0] {
		OCC_SRC_FRC = 3'h0,
		OCC_SRC_FRC_PLL = 3'h1,
		OCC_SRC_PRI = 3'h2,
		OCC_SRC_PRI_PLL = 3'h3,
		OCC_SRC_SEC = 3'h4,
		OCC_SRC_LOW_POWER_RC_OSCILLATOR = 3'h5,
		OCC_SRC_FRC_D16 = 3'h6,
		OCC_SRC_FRC_DIV = 3'h7
	} occ_src_t;

	typedef enum logic [1:0] {
		OCC_UNL_NONE = 2'h0,
		OCC_UNL_HALF = 2'h1,
		OCC_UNL_OPEN = 2'h3
	} occ_unl_t;

	typedef enum logic [1:0] {
		OCC_SW_IDLE = 2'h0,
		OCC_SW_WAIT = 2'h1,
		OCC_SW_DONE = 2'h3
	} occ_sw_t;

	// ************************************************************
	// Ratio decoding
	// ************************************************************
	function automatic logic [8:0] occ_div_ratio(input logic [2:0] code);
		occ_div_ratio = (code == 3'h7) ? 9'h100 : (9'h001 << code);
	endfunction

	function automatic logic [4:0] occ_mult_ratio(input logic [2:0] code);
		occ_mult_ratio = (code == 3'h7) ? 5'h18 : (5'h0f + {2'h0, code});
	endfunction

endpackage

// file: verif/occ_ctrl_tb_top.sv
// Self-checking testbench for the oscillator control register
`timescale 1ns/10ps

module occ_ctrl_tb_top;
	import occ_pkg::*;

	// ********
	// Signals
	// ********
	logic clk = 1'h0;
	logic nrst = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr;
	logic [2:0] cfg_src = 3'h0, cfg_odiv = 3'h0, cfg_mult = 3'h0;
	logic [1:0] cfg_mon = 2'h0, cfg_pb = 2'h3;
	logic cfg_sen = 1'h0, sosc_ok = 1'h0, usb_lk = 1'h0, sys_lk = 1'h0;
	logic fail = 1'h0, src_rdy = 1'h0;
	logic [2:0] cur_src;
	logic [8:0] odiv_ratio, frc_ratio;
	logic [4:0] mult_ratio;
	logic pb_en, slp_out, ufrc_out, sen_out;
	logic [2:0] e_odiv, e_frc, e_mult, e_current_source, e_new_source;
	logic [1:0] e_pb;
	logic e_lock, e_slp, e_cf, e_ufrc, e_sen;
	logic [31:0] rd;
	logic er;
	int seed = 52414;
	int err_total = 0;
	int n_tests = 0;

	always #12.5 clk = ~clk;

	occ_ctrl uut (
		.SYS_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.CFG_INITIAL_SOURCE(cfg_src), .CFG_SWITCH_MONITOR(cfg_mon),
		.CFG_PLL_OUTPUT_DIVIDER(cfg_odiv), .CFG_PLL_MULTIPLIER(cfg_mult),
		.CFG_PERIPH_BUS_DIVISOR(cfg_pb), .CFG_SECONDARY_OSC_ENABLE(cfg_sen),
		.SECONDARY_OSC_STABLE(sosc_ok), .USB_PLL_LOCKED(usb_lk), .SYSTEM_PLL_LOCKED(sys_lk),
		.FAIL_SAFE_MONITOR_FAIL(fail), .NEW_SOURCE_READY(src_rdy), .CURRENT_SOURCE(cur_src),
		.PLL_OUTPUT_RATIO(odiv_ratio), .FAST_RC_RATIO(frc_ratio), .PLL_MULT_RATIO(mult_ratio),
		.PERIPHERAL_BUS_CLOCK_EN(pb_en), .SLEEP_ON_WAIT(slp_out),
		.USB_FAST_RC_SELECT(ufrc_out), .SECONDARY_OSC_ENABLE(sen_out)
	);

	// ********
	// Expectations
	// ********
	function automatic logic [31:0] dv(input logic [2:0] c);
		dv = (c == 3'h7) ? 32'h100 : (32'h1 << c);
	endfunction

	// Reserved and read-only positions written as ones on purpose
	function automatic logic [31:0] mk(input logic osw);
		mk = {2'h3, e_odiv, e_frc, 3'h7, e_pb, e_mult, 4'hf, 1'h1, e_new_source, e_lock, 2'h3,
			e_slp, e_cf, e_ufrc, e_sen, osw};
	endfunction

	function automatic logic [31:0] ex(input logic osw);
		ex = {2'h0, e_odiv, e_frc, 1'h0, sosc_ok & e_sen, 1'h1, e_pb, e_mult, 1'h0, e_current_source,
			1'h0, e_new_source, e_lock, usb_lk, sys_lk, e_slp, e_cf, e_ufrc, e_sen, osw};
	endfunction

	// ********
	// Tasks
	// ********
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		// Request held until the edge where ready is sampled high
		@(posedge clk);
		while (pready !== 1'h1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (pready !== 1'h1) begin
			err_total++;
			$display("unexpected at %0t: bus timeout", $time);
			end_sim();
		end else begin
			rd = prdata;
			er = pslverr;
			psel <= 1'h0;
			penable <= 1'h0;
		end
	endtask

	task automatic rdc();
		apb(1'h0, OCC_CTRL_ADDR, 32'h0);
	endtask

	task automatic cwr(input logic osw);
		apb(1'h1, OCC_KEY_ADDR, OCC_KEY_FIRST);
		apb(1'h1, OCC_KEY_ADDR, OCC_KEY_SECOND);
		apb(1'h1, OCC_CTRL_ADDR, mk(osw));
	endtask

	// Config other than the switch monitor word is only sampled while reset is held
	task automatic do_reset();
		nrst <= 1'h0;
		repeat (12) @(posedge clk);
		nrst <= 1'h1;
		e_odiv = cfg_odiv;
		e_frc = 3'h1;
		e_pb = cfg_pb;
		e_mult = cfg_mult;
		e_current_source = 3'h0;
		e_new_source = cfg_src;
		{e_lock, e_slp, e_cf, e_ufrc} = 4'h0;
		e_sen = cfg_sen;
	endtask

	task automatic chk_out();
		repeat (2) @(negedge clk);
		chk(32'(odiv_ratio), dv(e_odiv), "pll out ratio");
		chk(32'(frc_ratio), dv(e_frc), "frc ratio");
		chk(32'(mult_ratio), (e_mult == 3'h7) ? 32'h18 : 32'hf + e_mult, "mult");
		chk(32'(cur_src), 32'(e_current_source), "current source");
		chk({29'h0, slp_out, ufrc_out, sen_out}, {29'h0, e_slp, e_ufrc, e_sen}, "bits");
	endtask

	// Ready may drop for a few cycles after a divisor change
	task automatic wait_rdy();
		int n;
		n = 0;
		rdc();
		while (rd[OCC_PBRDY_BIT] !== 1'h1 && n < 20) begin
			rdc();
			n++;
		end
		chk(32'(rd[OCC_PBRDY_BIT]), 32'h1, "divisor ready");
		if (rd[OCC_PBRDY_BIT] !== 1'h1) begin
			end_sim();
		end
	endtask

	task automatic tick_chk();
		int c;
		c = 0;
		repeat (32) begin
			@(negedge clk);
			if (pb_en === 1'h1) begin
				c++;
			end
		end
		chk(32'(c), 32'h20 >> e_pb, "tick count");
	endtask

	// ********
	// Sequence
	// ********
	initial begin
		int n;
		cfg_src = 3'($random(seed));
		cfg_odiv = 3'($random(seed));
		cfg_mult = 3'($random(seed));
		cfg_pb = 2'($random(seed));
		cfg_sen = 1'($random(seed));
		cfg_mon = {1'h0, 1'($random(seed))};
		do_reset();
		rdc();
		chk(rd, ex(1'h0), "reset word");
		chk_out();
		$display("reset test done");
		apb(1'h1, OCC_CTRL_ADDR, ~mk(1'h0));
		apb(1'h1, OCC_KEY_ADDR, OCC_KEY_FIRST);
		apb(1'h1, OCC_KEY_ADDR, 32'h0);
		apb(1'h1, OCC_CTRL_ADDR, ~mk(1'h0));
		rdc();
		chk(rd, ex(1'h0), "write without unlock");
		$display("unlock test done");
		for (int i = 0; i < 8; i++) begin
			e_odiv = 3'(i);
			e_frc = 3'h7 - 3'(i);
			e_mult = 3'(i) + 3'h3;
			e_pb = 2'($random(seed));
			{e_sen, e_ufrc, e_slp} = 3'(i);
			e_lock = 1'(i);
			@(posedge clk);
			sosc_ok <= 1'($random(seed));
			usb_lk <= 1'($random(seed));
			sys_lk <= 1'($random(seed));
			cwr(1'h0);
			wait_rdy();
			chk(rd, ex(1'h0), "field readback");
			chk_out();
			tick_chk();
		end
		$display("field test done");
		for (int k = 0; k < 8; k++) begin
			e_new_source = 3'(k + 1);
			cwr(1'h1);
			rdc();
			chk(rd, ex(1'h1), "switch pending");
			src_rdy <= 1'h1;
			n = 0;
			while (cur_src !== e_new_source && n < 20) begin
				@(negedge clk);
				n++;
			end
			if (cur_src !== e_new_source) begin
				err_total++;
				$display("unexpected at %0t: switch timeout", $time);
				end_sim();
			end
			@(posedge clk);
			src_rdy <= 1'h0;
			e_current_source = e_new_source;
			rdc();
			chk(rd, ex(1'h0), "switch done");
			chk_out();
		end
		$display("switch test done");
		@(posedge clk);
		fail <= 1'h1;
		@(posedge clk);
		fail <= 1'h0;
		e_cf = 1'h1;
		rdc();
		chk(rd, ex(1'h0), "fail flag set");
		e_cf = 1'h0;
		cwr(1'h0);
		rdc();
		chk(rd, ex(1'h0), "fail flag clear");
		apb(1'h0, 12'h020, 32'h0);
		chk({rd[31:1], er}, 32'h1, "unmapped read");
		$display("fail test done");
		cfg_mon <= 2'h2;
		cfg_src <= 3'($random(seed));
		do_reset();
		rdc();
		chk(rd, ex(1'h0), "second reset");
		e_lock = 1'h1;
		cwr(1'h0);
		e_mult = e_mult + 3'h1;
		e_odiv = e_odiv + 3'h1;
		e_new_source = e_new_source + 3'h1;
		e_slp = 1'h1;
		cwr(1'h0);
		e_mult = e_mult - 3'h1;
		e_odiv = e_odiv - 3'h1;
		e_new_source = e_new_source - 3'h1;
		rdc();
		chk(rd, ex(1'h0), "locked write");
		e_lock = 1'h0;
		cwr(1'h0);
		e_mult = e_mult + 3'h1;
		cwr(1'h0);
		rdc();
		chk(rd, ex(1'h0), "unlocked write");
		$display("lock test done");
		end_sim();
	end

endmodule // occ_ctrl_tb_top
